// ---- src/tmd_consts.svh ----
`ifndef TMD_CONSTS_SVH
`define TMD_CONSTS_SVH

// opcode fields, bits 15..10
`define TMD_OP6_PLL_LOAD     6'h3E
`define TMD_OP6_REG_TO_MEM   6'h0E
`define TMD_OP6_MEM_TO_REG   6'h0F
`define TMD_OP6_PORT_IN      6'h3A
`define TMD_OP6_PORT_OUT     6'h3B
// opcode fields, bits 15..8
`define TMD_OP8_DIR_WORD     8'hFE
`define TMD_OP8_ALL_ONES     8'hFC
`define TMD_OP8_ALL_ZEROS    8'hFD
// opcode fields, bits 15..4
`define TMD_OP12_HALT        12'h004
`define TMD_OP12_OSC_STOP    12'h005

// field positions
`define TMD_ADDR_HI          9
`define TMD_ADDR_LO          4
`define TMD_ROW_HIGH_HI      9
`define TMD_ROW_HIGH_LO      8
`define TMD_ROW_LOW_HI       7
`define TMD_ROW_LOW_LO       4
`define TMD_SEL_HI           3
`define TMD_SEL_LO           0

// reset values
`define TMD_HALT_RST         4'h0
`define TMD_DIR_RST          4'h0

`endif

// ---- src/tmd_pkg.sv ----
package tmd_pkg;
  typedef enum logic [1:0] {
    TMD_RUN     = 2'b00,
    TMD_HALTED  = 2'b01,
    TMD_OSC_OFF = 2'b10
  } tmd_state_t;
endpackage

// ---- src/tmd_sync2.sv ----
module tmd_sync2 #(
  parameter int W = 1
) (
  input  wire logic         CLK,
  input  wire logic         SYS_RST,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_meta = D;
    nxt_q    = meta_ff;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      meta_ff <= '0;
      Q       <= '0;
    end else begin
      meta_ff <= nxt_meta;
      Q       <= nxt_q;
    end
  end
endmodule // tmd_sync2

// ---- src/tmd_instr_decode.sv ----
`include "tmd_consts.svh"

// What this block does
// [RULE1] Opcode 111110 loads synthesizer register r from the memory nibble at the row address.
// [RULE2] Opcode 001110 copies the selected internal register to memory, 001111 the reverse.
// [RULE3] Opcode 11111110 writes bits 3..0 into the direction word picked by bits 7..4.
// [RULE4] Opcode 111010 reads the selected port into the memory nibble at bits 9..4.
// [RULE5] Opcode 111011 drives the selected port with the memory nibble at bits 9..4.
// [RULE6] Opcode 11111100 skips next op if masked port bits are all one, 11111101 if all zero.
// [RULE7] Opcode 000000000100 loads the halt register then stops the core clock until release.
// [RULE8] Opcode 000000000101 stops the oscillator only while the hold input is low.
module tmd_instr_decode
  import tmd_pkg::*;
#(
  parameter int NPORT = 16
) (
  input  wire logic                CLK,
  input  wire logic                SYS_RST,
  input  wire logic                INSTR_VALID,
  input  wire logic [15:0]         INSTR,
  input  wire logic [3:0]          MEM_RDATA,
  output logic                     MEM_WE,
  output logic      [5:0]          MEM_ADDR,
  output logic      [3:0]          MEM_WDATA,
  output logic      [5:0]          MEM_WADDR,
  input  wire logic [3:0]          REG_RDATA,
  output logic      [3:0]          REG_SEL,
  output logic                     REG_WE,
  output logic      [3:0]          REG_WDATA,
  output logic      [3:0]          REG_WSEL,
  output logic                     SYN_WE,
  output logic      [3:0]          SYN_SEL,
  output logic      [3:0]          SYN_WDATA,
  input  wire logic [NPORT*4-1:0]  PORT_IN,
  output logic      [NPORT*4-1:0]  PORT_OUT,
  output logic      [NPORT*4-1:0]  PORT_DIR,
  output logic                     SKIP_NEXT,
  output logic      [3:0]          HALT_CTRL,
  output logic                     CPU_CLK_STOP,
  input  wire logic                HALT_RELEASE,
  input  wire logic                HOLD,
  output logic                     OSC_STOP,
  output logic                     BUSY
);

  logic [NPORT*4-1:0] port_in_s;
  logic               hold_s;
  logic               release_s;

  tmd_sync2 #(.W(NPORT*4+2)) u_sync (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .D       ({PORT_IN, HOLD, HALT_RELEASE}),
    .Q       ({port_in_s, hold_s, release_s})
  );

  // field extraction
  logic [5:0]  op6;
  logic [7:0]  op8;
  logic [11:0] op12;
  logic [5:0]  mem_addr;
  logic [3:0]  sel_lo;
  logic [3:0]  sel_mid;
  logic [3:0]  tst_port;

  always_comb begin
    op6      = INSTR[15:10];
    op8      = INSTR[15:8];
    op12     = INSTR[15:4];
    mem_addr = {INSTR[`TMD_ROW_HIGH_HI:`TMD_ROW_HIGH_LO], INSTR[`TMD_ROW_LOW_HI:`TMD_ROW_LOW_LO]};
    sel_lo   = INSTR[`TMD_SEL_HI:`TMD_SEL_LO];
    sel_mid  = INSTR[7:4];
    tst_port = port_in_s[sel_mid*4 +: 4];
  end

  // read address is combinational so the read data is ready in the same cycle;
  // writes land one cycle later and use the registered MEM_WADDR and REG_WSEL
  always_comb begin
    MEM_ADDR = mem_addr;
    REG_SEL  = sel_lo;
  end

  logic [NPORT*4-1:0] port_out_ff, nxt_port_out;
  logic [NPORT*4-1:0] port_dir_ff, nxt_port_dir;
  logic [3:0]         halt_ff, nxt_halt;
  logic               mem_we_ff, nxt_mem_we;
  logic [3:0]         mem_wdata_ff, nxt_mem_wdata;
  // write target travels with its strobe: MEM_ADDR already follows the next word
  logic [5:0]         mem_waddr_ff, nxt_mem_waddr;
  logic               reg_we_ff, nxt_reg_we;
  logic [3:0]         reg_wdata_ff, nxt_reg_wdata;
  logic [3:0]         reg_wsel_ff, nxt_reg_wsel;
  logic               syn_we_ff, nxt_syn_we;
  logic [3:0]         syn_sel_ff, nxt_syn_sel;
  logic [3:0]         syn_wdata_ff, nxt_syn_wdata;
  logic               skip_ff, nxt_skip;
  tmd_state_t         state_ff, nxt_state;

  logic run;

  always_comb begin
    run           = INSTR_VALID && (state_ff == TMD_RUN);
    nxt_port_out  = port_out_ff;
    nxt_port_dir  = port_dir_ff;
    nxt_halt      = halt_ff;
    nxt_mem_we    = 1'b0;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_mem_waddr = mem_waddr_ff;
    nxt_reg_we    = 1'b0;
    nxt_reg_wdata = reg_wdata_ff;
    nxt_reg_wsel  = reg_wsel_ff;
    nxt_syn_we    = 1'b0;
    nxt_syn_sel   = syn_sel_ff;
    nxt_syn_wdata = syn_wdata_ff;
    nxt_skip      = 1'b0;
    nxt_state     = state_ff;

    if (run) begin
      case (op6)
        // [RULE1] synthesizer load
        `TMD_OP6_PLL_LOAD: begin
          nxt_syn_we    = 1'b1;
          nxt_syn_sel   = sel_lo;
          nxt_syn_wdata = MEM_RDATA;
        end
        // [RULE2] register to memory
        `TMD_OP6_REG_TO_MEM: begin
          nxt_mem_we    = 1'b1;
          nxt_mem_wdata = REG_RDATA;
          nxt_mem_waddr = mem_addr;
        end
        // [RULE2] memory to register
        `TMD_OP6_MEM_TO_REG: begin
          nxt_reg_we    = 1'b1;
          nxt_reg_wdata = MEM_RDATA;
          nxt_reg_wsel  = sel_lo;
        end
        // [RULE4] port into memory
        `TMD_OP6_PORT_IN: begin
          nxt_mem_we    = 1'b1;
          nxt_mem_wdata = port_in_s[sel_lo*4 +: 4];
          nxt_mem_waddr = mem_addr;
        end
        // [RULE5] memory out to port
        `TMD_OP6_PORT_OUT: begin
          nxt_port_out[sel_lo*4 +: 4] = MEM_RDATA;
        end
        default: begin
          case (op8)
            // [RULE3] direction word write
            `TMD_OP8_DIR_WORD: nxt_port_dir[sel_mid*4 +: 4] = sel_lo;
            // [RULE6] all ones skip
            `TMD_OP8_ALL_ONES: nxt_skip = ((tst_port & sel_lo) == sel_lo);
            // [RULE6] all zeros skip
            `TMD_OP8_ALL_ZEROS: nxt_skip = ((tst_port & sel_lo) == 4'h0);
            default: begin
              // [RULE7] halt entry
              if (op12 == `TMD_OP12_HALT) begin
                nxt_halt  = sel_lo;
                nxt_state = TMD_HALTED;
              end
              // [RULE8] oscillator stop gated by hold
              if (op12 == `TMD_OP12_OSC_STOP && !hold_s) begin
                nxt_state = TMD_OSC_OFF;
              end
            end
          endcase
        end
      endcase
    end else begin
      case (state_ff)
        // [RULE7] release wakes the clock
        TMD_HALTED:  if (release_s) nxt_state = TMD_RUN;
        // hold going high is the only way back once the crystal is stopped
        TMD_OSC_OFF: if (hold_s) nxt_state = TMD_RUN;
        default:     nxt_state = state_ff;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      port_out_ff  <= '0;
      port_dir_ff  <= {NPORT{`TMD_DIR_RST}};
      halt_ff      <= `TMD_HALT_RST;
      mem_we_ff    <= 1'b0;
      mem_wdata_ff <= 4'h0;
      mem_waddr_ff <= 6'h00;
      reg_we_ff    <= 1'b0;
      reg_wdata_ff <= 4'h0;
      reg_wsel_ff  <= 4'h0;
      syn_we_ff    <= 1'b0;
      syn_sel_ff   <= 4'h0;
      syn_wdata_ff <= 4'h0;
      skip_ff      <= 1'b0;
      state_ff     <= TMD_RUN;
    end else begin
      port_out_ff  <= nxt_port_out;
      port_dir_ff  <= nxt_port_dir;
      halt_ff      <= nxt_halt;
      mem_we_ff    <= nxt_mem_we;
      mem_wdata_ff <= nxt_mem_wdata;
      mem_waddr_ff <= nxt_mem_waddr;
      reg_we_ff    <= nxt_reg_we;
      reg_wdata_ff <= nxt_reg_wdata;
      reg_wsel_ff  <= nxt_reg_wsel;
      syn_we_ff    <= nxt_syn_we;
      syn_sel_ff   <= nxt_syn_sel;
      syn_wdata_ff <= nxt_syn_wdata;
      skip_ff      <= nxt_skip;
      state_ff     <= nxt_state;
    end
  end

  always_comb begin
    PORT_OUT     = port_out_ff;
    PORT_DIR     = port_dir_ff;
    HALT_CTRL    = halt_ff;
    MEM_WE       = mem_we_ff;
    MEM_WDATA    = mem_wdata_ff;
    MEM_WADDR    = mem_waddr_ff;
    REG_WE       = reg_we_ff;
    REG_WDATA    = reg_wdata_ff;
    REG_WSEL     = reg_wsel_ff;
    SYN_WE       = syn_we_ff;
    SYN_SEL      = syn_sel_ff;
    SYN_WDATA    = syn_wdata_ff;
    SKIP_NEXT    = skip_ff;
    CPU_CLK_STOP = (state_ff != TMD_RUN);
    OSC_STOP     = (state_ff == TMD_OSC_OFF);
    BUSY         = (state_ff != TMD_RUN);
  end
endmodule // tmd_instr_decode

// ---- dv/tmd_instr_decode_properties.sv ----
module tmd_instr_decode_chk #(
  parameter int NPORT = 16
) (
  input wire logic               CLK,
  input wire logic               SYS_RST,
  input wire logic               INSTR_VALID,
  input wire logic [15:0]        INSTR,
  input wire logic [3:0]         MEM_RDATA,
  input wire logic               MEM_WE,
  input wire logic [5:0]         MEM_WADDR,
  input wire logic [3:0]         MEM_WDATA,
  input wire logic [3:0]         REG_RDATA,
  input wire logic               REG_WE,
  input wire logic [3:0]         REG_WSEL,
  input wire logic [3:0]         REG_WDATA,
  input wire logic               SYN_WE,
  input wire logic [3:0]         SYN_SEL,
  input wire logic [3:0]         SYN_WDATA,
  input wire logic [NPORT*4-1:0] PORT_OUT,
  input wire logic [NPORT*4-1:0] PORT_DIR,
  input wire logic               SKIP_NEXT,
  input wire logic [3:0]         HALT_CTRL,
  input wire logic               CPU_CLK_STOP,
  input wire logic               OSC_STOP,
  input wire logic               BUSY
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  wire tk = INSTR_VALID && !BUSY;
  property p_syn; tk && INSTR[15:10] == 6'h3E |=> SYN_WE && SYN_SEL == $past(INSTR[3:0])
    && SYN_WDATA == $past(MEM_RDATA); endproperty
  a_syn: assert property (p_syn) else $error("synth load wrong");
  property p_r2m; tk && INSTR[15:10] == 6'h0E |=> MEM_WE && MEM_WDATA == $past(REG_RDATA)
    && MEM_WADDR == $past(INSTR[9:4]); endproperty
  a_r2m: assert property (p_r2m) else $error("reg to mem wrong");
  property p_m2r; tk && INSTR[15:10] == 6'h0F |=> REG_WE && REG_WDATA == $past(MEM_RDATA)
    && REG_WSEL == $past(INSTR[3:0]); endproperty
  a_m2r: assert property (p_m2r) else $error("mem to reg wrong");
  property p_dir; tk && INSTR[15:8] == 8'hFE |=>
    PORT_DIR[4*$past(INSTR[7:4]) +: 4] == $past(INSTR[3:0]); endproperty
  a_dir: assert property (p_dir) else $error("dir word wrong");
  property p_pin; tk && INSTR[15:10] == 6'h3A |=> MEM_WE && !REG_WE
    && MEM_WADDR == $past(INSTR[9:4]); endproperty
  a_pin: assert property (p_pin) else $error("port in no write");
  property p_pout; tk && INSTR[15:10] == 6'h3B |=>
    PORT_OUT[4*$past(INSTR[3:0]) +: 4] == $past(MEM_RDATA); endproperty
  a_pout: assert property (p_pout) else $error("port out wrong");
  property p_skip; SKIP_NEXT |-> $past(tk && INSTR[15:9] == 7'h7E); endproperty
  a_skip: assert property (p_skip) else $error("stray skip");
  property p_halt; tk && INSTR[15:4] == 12'h004 |=> HALT_CTRL == $past(INSTR[3:0])
    && CPU_CLK_STOP && BUSY; endproperty
  a_halt: assert property (p_halt) else $error("halt wrong");
  property p_osc; $rose(OSC_STOP) |-> $past(tk && INSTR[15:4] == 12'h005); endproperty
  a_osc: assert property (p_osc) else $error("stray osc stop");
endmodule // tmd_instr_decode_chk

// ---- dv/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, SYS_RST = 1, INSTR_VALID = 0, HALT_RELEASE = 0, HOLD = 1;
  logic [15:0] INSTR = 16'h0000;
  logic [63:0] PORT_IN = 64'h0, PORT_OUT, PORT_DIR;
  logic MEM_WE, REG_WE, SYN_WE, SKIP_NEXT, CPU_CLK_STOP, OSC_STOP, BUSY;
  logic [5:0] MEM_ADDR, MEM_WADDR;
  logic [3:0] MEM_WDATA, REG_SEL, REG_WDATA, SYN_SEL, SYN_WDATA, HALT_CTRL, MEM_RDATA, REG_RDATA;
  logic [3:0] REG_WSEL;
  logic [3:0] mem [64], regs [16], wd;
  logic [11:0] got;
  logic [15:0] q [$], e;
  logic [31:0] k;
  logic [5:0] ops [4] = '{6'h3E, 6'h0E, 6'h0F, 6'h3B};
  int n_mismatch = 0, total_checks = 0, seed = 32'h762E1594;
  assign MEM_RDATA = mem[MEM_ADDR];
  assign REG_RDATA = regs[REG_SEL];
  tmd_instr_decode tmd_instr_decode_i (
    .CLK(CLK), .SYS_RST(SYS_RST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
    .MEM_RDATA(MEM_RDATA), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_WADDR(MEM_WADDR), .REG_RDATA(REG_RDATA), .REG_SEL(REG_SEL), .REG_WE(REG_WE),
    .REG_WDATA(REG_WDATA), .REG_WSEL(REG_WSEL), .SYN_WE(SYN_WE), .SYN_SEL(SYN_SEL),
    .SYN_WDATA(SYN_WDATA), .PORT_IN(PORT_IN), .PORT_OUT(PORT_OUT), .PORT_DIR(PORT_DIR),
    .SKIP_NEXT(SKIP_NEXT), .HALT_CTRL(HALT_CTRL), .CPU_CLK_STOP(CPU_CLK_STOP),
    .HALT_RELEASE(HALT_RELEASE), .HOLD(HOLD), .OSC_STOP(OSC_STOP), .BUSY(BUSY)
  );
  initial forever #10 CLK = ~CLK;
  task automatic chk(string s, logic [15:0] x, logic [15:0] g);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %s exp %h got %h", s, x, g);
    end
  endtask
  // write strobes with their target and data
  task automatic chk_wr(string s, logic [15:0] x, logic [15:0] g);
    chk(s, x, g);
  endtask
  // latched port words and control registers
  task automatic chk_lat(string s, logic [15:0] x, logic [15:0] g);
    chk(s, x, g);
  endtask
  // single status bits and pulses
  task automatic chk_flag(string s, logic x, logic g);
    chk(s, {15'h0000, x}, {15'h0000, g});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // expected writes noted before issue; held valid gives back-to-back issue
  task automatic run(logic [15:0] w);
    logic [5:0] a;
    logic [3:0] s;
    a = w[9:4];
    s = w[3:0];
    INSTR = w;
    INSTR_VALID = 1;
    case (w[15:10])
      6'h3E: q.push_back({4'h4, 4'h0, s, mem[a]});
      6'h0E: q.push_back({4'h1, 2'b00, a, regs[s]});
      6'h0F: q.push_back({4'h2, 4'h0, s, mem[a]});
      6'h3A: q.push_back({4'h1, 2'b00, a, PORT_IN[4*s +: 4]});
      default: ;
    endcase
    @(negedge CLK);
    if (w[15:10] == 6'h3B) chk_lat("port_out", mem[a], PORT_OUT[4*s +: 4]);
    if (w[15:8] == 8'hFE) chk_lat("port_dir", s, PORT_DIR[4*w[7:4] +: 4]);
  endtask
  always @(posedge CLK) begin
    #1;
    if (MEM_WE | REG_WE | SYN_WE) begin
      if (MEM_WE) got = {2'b00, MEM_WADDR, MEM_WDATA};
      else if (REG_WE) got = {4'h0, REG_WSEL, REG_WDATA};
      else got = {4'h0, SYN_SEL, SYN_WDATA};
      e = q.pop_front();
      chk_wr("write", e, {1'b0, SYN_WE, REG_WE, MEM_WE, got});
    end
  end
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = $random(seed);
    for (int i = 0; i < 16; i++) regs[i] = $random(seed);
    repeat (2) @(negedge CLK);
    SYS_RST = 0;
    for (int i = 0; i < 40; i++) begin
      k = $random(seed);
      run({ops[k[1:0]], k[13:4]});
    end
    for (int i = 0; i < 16; i++) begin
      k = $random(seed);
      run({8'hFE, i[3:0], k[3:0]});
    end
    INSTR_VALID = 0;
    PORT_IN = {$random(seed), $random(seed)};
    repeat (3) @(negedge CLK);
    for (int i = 0; i < 16; i++) begin
      k = $random(seed);
      run({6'h3A, k[5:0], i[3:0]});
    end
    // random mask on each port word, sense picked by k[0]
    for (int i = 0; i < 32; i++) begin
      k = $random(seed);
      run({7'h7E, k[0], i[3:0], k[7:4]});
      wd = PORT_IN[4*i[3:0] +: 4] & k[7:4];
      chk_flag("skip", k[0] ? wd == 4'h0 : wd == k[7:4], SKIP_NEXT);
    end
    run(16'h0049);
    INSTR_VALID = 0;
    chk_lat("halt_ctrl", 16'h0009, HALT_CTRL);
    chk_flag("halt_busy", 1'b1, {BUSY, CPU_CLK_STOP} == 2'b11);
    HALT_RELEASE = 1;
    for (int i = 0; i < 10 && BUSY; i++) @(negedge CLK);
    chk_flag("halt_exit", 1'b0, BUSY);
    HALT_RELEASE = 0;
    run(16'h0050);
    INSTR_VALID = 0;
    chk_flag("osc_held", 1'b0, OSC_STOP);
    HOLD = 0;
    repeat (3) @(negedge CLK);
    run(16'h0050);
    INSTR_VALID = 0;
    chk_flag("osc_stop", 1'b1, OSC_STOP);
    HOLD = 1;
    for (int i = 0; i < 10 && BUSY; i++) @(negedge CLK);
    chk_flag("osc_exit", 1'b0, BUSY);
    repeat (3) @(negedge CLK);
    chk("pending", 16'h0000, 16'(q.size()));
    give_verdict();
  end
endmodule // tb

bind tmd_instr_decode tmd_instr_decode_chk #(.NPORT(NPORT)) chk_i (
  .CLK(CLK), .SYS_RST(SYS_RST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
  .MEM_RDATA(MEM_RDATA), .MEM_WE(MEM_WE), .MEM_WADDR(MEM_WADDR), .MEM_WDATA(MEM_WDATA),
  .REG_RDATA(REG_RDATA), .REG_WE(REG_WE), .REG_WSEL(REG_WSEL), .REG_WDATA(REG_WDATA),
  .SYN_WE(SYN_WE), .SYN_SEL(SYN_SEL), .SYN_WDATA(SYN_WDATA), .PORT_OUT(PORT_OUT),
  .PORT_DIR(PORT_DIR), .SKIP_NEXT(SKIP_NEXT), .HALT_CTRL(HALT_CTRL),
  .CPU_CLK_STOP(CPU_CLK_STOP), .OSC_STOP(OSC_STOP), .BUSY(BUSY)
);
